// File: hw/scl_timing_regs.v
// scl low/high timing generator and receive-port control registers
//
// Functional notes
// - as controller, scl is held low for the programmed clock-low count
// - on remote accesses the low count is sda setup before scl release
// - one count unit is one osc_tick pulse, which comes every clock here, so 100 ns
// - low time equals count plus five oscillator periods
// - clock-low count resets to 0x7a, about 39 kHz with the high count at 100 ns units
// - port control resets to 0x0f, sets lock/pass and port enables
// - bit 7 maps control channel 3 to target port 0 or 1
// - scl high width set by separate clock-high count, same units
`default_nettype none
`include "scl_timing_defs.vh"
module scl_timing_regs (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe,
    output reg sda_release_q,
    output reg [7:0] port_ctl_q,
    output reg chan3_target_port_select
);
    localparam ST_IDLE = 3'b001;
    localparam ST_LOW = 3'b010;
    localparam ST_HIGH = 3'b100;
    reg [2:0] state_q;
    reg [8:0] cnt_q;
    reg [7:0] low_q;
    reg [7:0] high_q;
    reg run_q;
    reg remote_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg wlane0_q;
    reg aw_have_q;
    reg w_have_q;
    wire tick;
    wire [8:0] low_end;
    wire [8:0] high_end;
    wire do_write;

    osc_tick u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick_q(tick)
    );

    // count plus five extra oscillator periods
    assign low_end = {1'b0, low_q} + {1'b0, `EXTRA_CYCLES};
    assign high_end = {1'b0, high_q} + {1'b0, `EXTRA_CYCLES};
    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

    // write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wlane0_q <= 1'b0;
            low_q <= `RST_SCL_LOW;
            high_q <= `RST_SCL_HIGH;
            port_ctl_q <= `RST_PORT_CTL;
            chan3_target_port_select <= 1'b0;
            run_q <= 1'b0;
            remote_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wlane0_q <= s_axi_wstrb[0];
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                case (awaddr_q)
                    `OFS_SCL_HIGH: if (wlane0_q) high_q <= wdata_q[7:0];
                    `OFS_SCL_LOW: if (wlane0_q) low_q <= wdata_q[7:0];
                    `OFS_PORT_CTL: if (wlane0_q) begin
                        port_ctl_q <= wdata_q[7:0];
                        chan3_target_port_select <=
                            wdata_q[`BIT_CHAN3_MAP];
                    end
                    `OFS_SCL_CTL: if (wlane0_q) begin
                        run_q <= wdata_q[0];
                        remote_q <= wdata_q[1];
                    end
                    `OFS_SCL_STAT: ;
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // read channel: one outstanding read, answered the cycle after arvalid
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
                `OFS_SCL_HIGH: s_axi_rdata <= {24'h000000, high_q};
                `OFS_SCL_LOW: s_axi_rdata <= {24'h000000, low_q};
                `OFS_PORT_CTL: s_axi_rdata <= {24'h000000, port_ctl_q};
                `OFS_SCL_CTL: s_axi_rdata <= {30'h0, remote_q, run_q};
                `OFS_SCL_STAT: s_axi_rdata <= {28'h0, state_q, scl_out};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // scl generator; counts oscillator ticks, so drift follows the
    // oscillator and software must leave margin for it
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 9'h000;
            scl_out <= 1'b1;
            scl_oe <= 1'b0;
            sda_release_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    scl_out <= 1'b1;
                    scl_oe <= 1'b0;
                    cnt_q <= 9'h000;
                    if (run_q && tick) begin
                        state_q <= ST_LOW;
                        scl_out <= 1'b0;
                        scl_oe <= 1'b1;
                        sda_release_q <= 1'b0;
                    end
                end
                ST_LOW: begin
                    scl_out <= 1'b0;
                    scl_oe <= 1'b1;
                    if (tick) begin
                        // one unit per oscillator tick
                        if (cnt_q + 9'h001 >= low_end) begin
                            state_q <= ST_HIGH;
                            cnt_q <= 9'h000;
                            scl_out <= 1'b1;
                            scl_oe <= 1'b0;
                            // on remote accesses sda released for the whole high phase
                            sda_release_q <= remote_q;
                        end else begin
                            cnt_q <= cnt_q + 9'h001;
                        end
                    end
                end
                ST_HIGH: begin
                    scl_out <= 1'b1;
                    scl_oe <= 1'b0;
                    // a target stretching scl holds the high count off
                    if (tick && scl_in) begin
                        if (cnt_q + 9'h001 >= high_end) begin
                            cnt_q <= 9'h000;
                            sda_release_q <= 1'b0;
                            if (run_q) begin
                                state_q <= ST_LOW;
                                scl_out <= 1'b0;
                                scl_oe <= 1'b1;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            cnt_q <= cnt_q + 9'h001;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: hw/scl_timing_defs.vh
// register map, field positions, reset values and timing counts
`ifndef SCL_TIMING_DEFS_VH
`define SCL_TIMING_DEFS_VH
// register indices; the byte address is four times the index
`define IDX_SCL_HIGH 12'h00a
`define IDX_SCL_LOW 12'h00b
`define IDX_PORT_CTL 12'h00c
`define IDX_SCL_CTL 12'h00d
`define IDX_SCL_STAT 12'h00e
`define OFS_SCL_HIGH (`IDX_SCL_HIGH << 2)
`define OFS_SCL_LOW (`IDX_SCL_LOW << 2)
`define OFS_PORT_CTL (`IDX_PORT_CTL << 2)
`define OFS_SCL_CTL (`IDX_SCL_CTL << 2)
`define OFS_SCL_STAT (`IDX_SCL_STAT << 2)
`define RST_SCL_HIGH 8'h7a
`define RST_SCL_LOW 8'h7a
`define RST_PORT_CTL 8'h0f
`define EXTRA_CYCLES 8'h05
`define BIT_CHAN3_MAP 7
`define OSC_PERIOD_PS 40000
`define CLK_PERIOD_PS 100000
// clock is slower than one unit, so every clock counts as one unit;
// a unit is therefore 100 ns here, not 40 ns
`define OSC_TICK_LAST 4'h0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: hw/osc_tick.v
// divider that yields the oscillator-period enable pulse
`default_nettype none
`include "scl_timing_defs.vh"
module osc_tick (
    input wire aclk,
    input wire aresetn,
    output reg tick_q
);
    reg [3:0] cnt_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 4'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == `OSC_TICK_LAST) begin
            cnt_q <= 4'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
            tick_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: tb/i2c_target_model.sv
// local-bus target side: resolves the scl wire seen by the controller
`default_nettype none
module i2c_target_model (
    input wire logic scl_oe,
    input wire logic scl_out,
    output logic scl_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull-up wins whenever nobody drives, so idle never reads unknown
    assign scl_line = scl_oe ? scl_out : 1'b1;
endmodule
`default_nettype wire

// File: tb/scl_timing_properties.sv
// concurrent checks on the scl timing and register port signals
`default_nettype none
module scl_timing_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_release_q,
    input wire logic [7:0] port_ctl_q,
    input wire logic chan3_target_port_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // shortest legal low phase is a zero count plus the fixed five
    sequence low_run;
        !scl_out [*5];
    endsequence
    chk_oe_low_drive: assert property (scl_oe |-> !scl_out)
        else $error("scl driven while not low");
    chk_fall_oe: assert property ($fell(scl_out) |-> $rose(scl_oe))
        else $error("scl fall without drive enable");
    chk_reset_ports: assert property ($rose(aresetn) |->
        port_ctl_q == 8'h0f && !chan3_target_port_select)
        else $error("port control reset value wrong");
    chk_chan3_map: assert property (
        chan3_target_port_select == port_ctl_q[7])
        else $error("channel 3 select differs from bit 7");
    chk_low_min: assert property ($fell(scl_out) |-> low_run)
        else $error("scl low phase too short");
    chk_low_bound: assert property (
        $fell(scl_out) |-> ##[1:260] scl_out)
        else $error("scl low phase too long");
    chk_release_high: assert property (
        sda_release_q |-> scl_out && !scl_oe)
        else $error("sda release outside scl high");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_write_done: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid)
        else $error("write response held after handshake");
endmodule
bind scl_timing_regs scl_timing_props u_scl_timing_props (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_release_q(sda_release_q),
    .port_ctl_q(port_ctl_q),
    .chan3_target_port_select(chan3_target_port_select)
);
`default_nettype wire

// File: tb/i2c_scl_low_timing_port_map_bench.sv
// self-checking bench for scl timing and port control registers
`default_nettype none
`include "scl_timing_defs.vh"
module i2c_scl_low_timing_port_map_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, scl_in, scl_out, scl_oe, sda_release_q;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid, s_axi_bvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] port_ctl_q;
    logic chan3_target_port_select;
    int bad_count = 0, samples_checked = 0;
    always #50 aclk = ~aclk;
    scl_timing_regs u_scl_timing_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .scl_in(scl_in),
        .scl_out(scl_out),
        .scl_oe(scl_oe),
        .sda_release_q(sda_release_q),
        .port_ctl_q(port_ctl_q),
        .chan3_target_port_select(chan3_target_port_select)
    );
    i2c_target_model u_i2c_target_model (.scl_oe, .scl_out,
        .scl_line(scl_in));
    task automatic cmp(input string n, input logic [31:0] e,
            input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] r);
        logic pa, pw, pb;
        pa = 1;
        pw = 1;
        pb = 1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // no cycle limit here: only the watchdog ends a stuck handshake
        while (pb) begin
            @(posedge aclk);
            if (s_axi_awready) pa = 0;
            if (s_axi_wready) pw = 0;
            if (s_axi_bvalid) pb = 0;
            s_axi_awvalid <= pa;
            s_axi_wvalid <= pw;
            s_axi_bready <= pb;
        end
        cmp("bresp", r, s_axi_bresp);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
            input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        cmp("rdata", e, s_axi_rdata);
        cmp("rresp", r, s_axi_rresp);
    endtask
    // counts sampled cycles of each scl phase, bounded against a hang
    task automatic meas(input int lo, input int hi, input logic rel);
        int n;
        int nrel;
        n = 0;
        nrel = 0;
        // sync to a fresh fall so a phase already under way is skipped
        while (scl_out !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        while (scl_out !== 1'b0 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        n = 0;
        while (scl_out === 1'b0 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        cmp("low_width", lo + 5, n);
        n = 0;
        while (scl_out === 1'b1 && n < 400) begin
            if (sda_release_q === 1'b1) nrel++;
            @(posedge aclk);
            n++;
        end
        cmp("high_width", hi + 5, n);
        cmp("sda_release", rel ? hi + 5 : 0, nrel);
    endtask
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_SCL_LOW, 32'h7a, `RESP_OKAY);
        rd(`OFS_SCL_HIGH, 32'h7a, `RESP_OKAY);
        rd(`OFS_PORT_CTL, 32'h0f, `RESP_OKAY);
        cmp("chan3", 0, chan3_target_port_select);
        rd(12'h100, 32'h0, `RESP_SLVERR);
        wr(12'h100, 32'h55, 4'h1, `RESP_SLVERR);
        wr(`OFS_PORT_CTL, 32'h8f, 4'h1, `RESP_OKAY);
        wr(`OFS_PORT_CTL, 32'h0, 4'h0, `RESP_OKAY);
        rd(`OFS_PORT_CTL, 32'h8f, `RESP_OKAY);
        cmp("chan3", 1, chan3_target_port_select);
        wr(`OFS_PORT_CTL, 32'h0f, 4'h1, `RESP_OKAY);
        cmp("chan3", 0, chan3_target_port_select);
        // short counts keep margin for oscillator drift small here
        wr(`OFS_SCL_LOW, 32'h3, 4'h1, `RESP_OKAY);
        wr(`OFS_SCL_HIGH, 32'h4, 4'h1, `RESP_OKAY);
        rd(`OFS_SCL_LOW, 32'h3, `RESP_OKAY);
        wr(`OFS_SCL_CTL, 32'h3, 4'h1, `RESP_OKAY);
        meas(3, 4, 1'b1);
        rd(`OFS_SCL_CTL, 32'h3, `RESP_OKAY);
        meas(3, 4, 1'b1);
        wr(`OFS_SCL_CTL, 32'h1, 4'h1, `RESP_OKAY);
        meas(3, 4, 1'b0);
        wr(`OFS_SCL_CTL, 32'h0, 4'h1, `RESP_OKAY);
        // stopping finishes the phases under way, at most low plus high
        repeat (20) @(posedge aclk);
        cmp("scl_idle", 1, scl_out);
        cmp("scl_oe_idle", 0, scl_oe);
        rd(`OFS_SCL_STAT, 32'h3, `RESP_OKAY);
        end_of_test;
    end
endmodule
`default_nettype wire
